/* hdl/flash_array.sv */
// Byte-wide memory array standing in for the flash die, read data registered.
// Assumes one write port from the register bus and one read port from the engine.
module flash_array #(
  parameter int ADDR_BITS = 10
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [ADDR_BITS-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [ADDR_BITS-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [2**ADDR_BITS];

  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule // flash_array

/* hdl/flash_cmd_pkg.sv */
// Constants and types shared by the serial flash command front end.
// Assumes a 50 MHz system clock and a Wishbone classic register bus.
package flash_cmd_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_EXT = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_RADDR = 8'h14;
  localparam logic [7:0] REG_MEMADDR = 8'h18;
  localparam logic [7:0] REG_MEMDATA = 8'h1c;
  // Field positions
  localparam int CTRL_DTR_BIT = 2;
  localparam int CTRL_ADDR4_BIT = 3;
  localparam int FL_WIP = 0;
  localparam int FL_PEC = 1;
  localparam int FL_PROT = 4;
  localparam int FL_WEL = 8;
  localparam logic [4:0] FLAG_ERR_MASK = 5'h1c;
  // Reset values and the nonvolatile reserved mask
  localparam logic [4:0] FLAGS_RESET = 5'h02;
  localparam logic [15:0] NVCR_RESET = 16'hffff;
  localparam logic [15:0] NVCR_RSVD_MASK = 16'h0010;
  localparam logic [7:0] VCR_RESET = 8'hfb;
  localparam logic [7:0] EVCR_RESET = 8'hdf;
  // Lane modes as log2 of the lane count
  localparam logic [1:0] LANE_ONE = 2'h0;
  localparam logic [1:0] LANE_TWO = 2'h1;
  localparam logic [1:0] LANE_FOUR = 2'h2;
  // Frame figures
  localparam logic [3:0] CMD_BITS = 4'h8;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_WORD = 4'h4;
  // Opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_FAST4 = 8'h0c;
  localparam logic [7:0] OP_DOUT = 8'h3b;
  localparam logic [7:0] OP_DOUT4 = 8'h3c;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_DIO4 = 8'hbc;
  localparam logic [7:0] OP_QOUT = 8'h6b;
  localparam logic [7:0] OP_QOUT4 = 8'h6c;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_QIO4 = 8'hec;
  localparam logic [7:0] OP_WORD = 8'he7;
  localparam logic [7:0] OP_DTR_FAST = 8'h0d;
  localparam logic [7:0] OP_DTR_FAST4 = 8'h0e;
  localparam logic [7:0] OP_DTR_DOUT = 8'h3d;
  localparam logic [7:0] OP_DTR_DIO = 8'hbd;
  localparam logic [7:0] OP_DTR_QOUT = 8'h6d;
  localparam logic [7:0] OP_DTR_QIO = 8'hed;
  localparam logic [7:0] OP_WEN = 8'h06;
  localparam logic [7:0] OP_WDIS = 8'h04;
  localparam logic [7:0] OP_CLRFLAG = 8'h50;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_RD_FLAG = 8'h70;
  localparam logic [7:0] OP_RD_NV = 8'hb5;
  localparam logic [7:0] OP_RD_VOL = 8'h85;
  localparam logic [7:0] OP_RD_EVOL = 8'h65;
  localparam logic [7:0] OP_RD_EXT = 8'hc8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_OPC = 3'h1, ST_ADR = 3'h3, ST_DUM = 3'h2,
    ST_DAT = 3'h6, ST_HOLD = 3'h7, ST_IGN = 3'h5
  } state_type;
  typedef enum logic [1:0] {KIND_NONE, KIND_MEM, KIND_REG, KIND_LATCH} kind_type;
  typedef struct packed {
    kind_type kind;
    logic [1:0] addrLog;
    logic [1:0] dataLog;
    logic dtr;
    logic wide;
    logic [3:0] dummy;
  } cmd_type;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;
  typedef struct packed {
    logic [3:0] data;
    logic [3:0] oen;
  } lanes_out_type;
endpackage

/* hdl/serial_flash_front.sv */
// Command front end of a serial NOR flash: reads, latch commands, register reads.
// Assumes serial pins slow against clk and a Wishbone classic master.
module serial_flash_front #(
  parameter int MEM_BITS = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input flash_cmd_pkg::wb_req_type wbReq,
  output flash_cmd_pkg::wb_rsp_type wbRsp,
  input wire logic sclkPin,
  input wire logic selectN,
  input wire logic [3:0] laneIn,
  output flash_cmd_pkg::lanes_out_type laneDrive
);
  import flash_cmd_pkg::*;

  logic rstMeta, rstn, sclkNow, selN, sclkLast, rise, fall;
  logic [5:0] pinSync;
  logic [3:0] lanes;
  state_type state, next_state;
  cmd_type cmd, liveCmd;
  logic [31:0] opWide, addrShift, addrNext, readAddr, rdMux, wdat;
  logic [7:0] opShift, opNext, opcode, riseCnt, lastIdx, liveIdx, curIdx;
  logic [7:0] regByte, memData, outShift, statusByte, flagByte;
  logic [3:0] opBits, dumCnt, outLeft, dataStep, addrStep, driveMask, driveBits;
  logic [5:0] addrBits, addrWidth;
  logic [1:0] byteIdx, laneMode;
  logic opDone, addrEdge, addrDone, outEdge, loadByte, primed, active;
  logic latchExec, welSet, welClr, flagClr, dtrEn, addr4, wel, hit, wr, memWr;
  logic [4:0] flags;
  logic [15:0] nvcr;
  logic [7:0] vcr, evcr, extAddr;
  logic [5:0] srHigh;
  logic [MEM_BITS-1:0] memAddr;

  function automatic logic [31:0] shiftIn(input logic [31:0] v, input logic [1:0] lg,
    input logic [3:0] d);
    case (lg)
      LANE_ONE: shiftIn = {v[30:0], d[0]};
      LANE_TWO: shiftIn = {v[29:0], d[1:0]};
      default: shiftIn = {v[27:0], d};
    endcase
  endfunction

  function automatic cmd_type decode(input logic [7:0] op, input logic [1:0] mode,
    input logic dtrOn, input logic wideOn);
    cmd_type c;
    c.kind = KIND_MEM;
    c.addrLog = mode;
    c.dataLog = mode;
    c.dtr = dtrOn | (op inside {OP_DTR_FAST, OP_DTR_FAST4, OP_DTR_DOUT, OP_DTR_DIO,
      OP_DTR_QOUT, OP_DTR_QIO});
    c.wide = wideOn | (op inside {OP_READ4, OP_FAST4, OP_DOUT4, OP_DIO4, OP_QOUT4,
      OP_QIO4, OP_DTR_FAST4});
    c.dummy = DUMMY_FAST;
    case (op)
      OP_READ, OP_READ4: c.dummy = 4'h0;
      OP_FAST, OP_FAST4, OP_DTR_FAST, OP_DTR_FAST4: c.dummy = DUMMY_FAST;
      OP_DOUT, OP_DOUT4, OP_DTR_DOUT:
      begin
        c.dataLog = LANE_TWO;
        if (mode == LANE_FOUR)
          c.kind = KIND_NONE;
      end
      OP_DIO, OP_DIO4, OP_DTR_DIO:
      begin
        c.addrLog = (op == OP_DTR_DIO && mode == LANE_TWO) ? LANE_FOUR : LANE_TWO;
        c.dataLog = LANE_TWO;
        if (mode == LANE_FOUR)
          c.kind = KIND_NONE;
      end
      OP_QOUT, OP_QOUT4, OP_DTR_QOUT:
      begin
        c.dataLog = LANE_FOUR;
        if (mode == LANE_TWO)
          c.kind = KIND_NONE;
      end
      OP_QIO, OP_QIO4, OP_DTR_QIO:
      begin
        c.addrLog = LANE_FOUR;
        c.dataLog = LANE_FOUR;
      end
      OP_WORD:
      begin
        c.addrLog = LANE_FOUR;
        c.dataLog = LANE_FOUR;
        c.dummy = DUMMY_WORD;
        if (mode == LANE_TWO || dtrOn)
          c.kind = KIND_NONE;
      end
      OP_RD_STATUS, OP_RD_FLAG, OP_RD_NV, OP_RD_VOL, OP_RD_EVOL, OP_RD_EXT:
        c.kind = KIND_REG;
      OP_WEN, OP_WDIS, OP_CLRFLAG: c.kind = KIND_LATCH;
      default: c.kind = KIND_NONE;
    endcase
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end

  sync_two #(.WIDTH(6), .INIT(6'h10)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({sclkPin, selectN, laneIn}),
    .dout(pinSync)
  );

  flash_array #(.ADDR_BITS(MEM_BITS)) u_array (
    .clk(clk),
    .wrEn(memWr),
    .wrAddr(memAddr),
    .wrData(wbReq.dat[7:0]),
    .rdAddr(readAddr[MEM_BITS-1:0]),
    .rdData(memData)
  );

  assign sclkNow = pinSync[5];
  assign selN = pinSync[4];
  assign lanes = pinSync[3:0];
  assign rise = sclkNow & ~sclkLast;
  assign fall = ~sclkNow & sclkLast;
  assign opWide = shiftIn({24'h0, opShift}, laneMode, lanes);
  assign opNext = opWide[7:0];
  assign opDone = (state == ST_OPC) && rise && ((opBits + (4'h1 << laneMode)) == CMD_BITS);
  assign liveCmd = decode(opNext, laneMode, dtrEn, addr4);
  assign liveIdx = (8'h08 >> laneMode) - 8'h01
    + ({2'h0, (liveCmd.wide ? ADDR4_BITS : ADDR3_BITS)}
    >> ({1'b0, liveCmd.addrLog} + {2'h0, liveCmd.dtr}));
  assign addrStep = 4'h1 << cmd.addrLog;
  assign addrWidth = cmd.wide ? ADDR4_BITS : ADDR3_BITS;
  assign addrEdge = rise | (cmd.dtr & fall & (addrBits != 6'h0));
  assign addrNext = shiftIn(addrShift, cmd.addrLog, lanes);
  assign addrDone = (state == ST_ADR) && addrEdge && ((addrBits + {2'h0, addrStep}) == addrWidth);
  assign curIdx = rise ? riseCnt : riseCnt - 8'h01;
  assign dataStep = 4'h1 << cmd.dataLog;
  assign outEdge = (state == ST_DAT) && (fall | (cmd.dtr & rise & primed));
  assign loadByte = outEdge && (!primed || outLeft == dataStep);
  assign latchExec = (state == ST_HOLD) && selN;
  assign welSet = latchExec && opcode == OP_WEN;
  assign welClr = latchExec && ((opcode == OP_WDIS && !flags[FL_PROT])
    || opcode == OP_CLRFLAG);
  assign flagClr = latchExec && opcode == OP_CLRFLAG;
  assign statusByte = {srHigh, wel, flags[FL_WIP]};
  assign flagByte = {flags[FL_PEC], 1'b0, flags[2], flags[3], 2'h0, flags[FL_PROT], addr4};
  assign regByte = opcode == OP_RD_STATUS ? statusByte
    : opcode == OP_RD_FLAG ? flagByte
    : opcode == OP_RD_NV ? (byteIdx == 2'h0 ? nvcr[7:0] | NVCR_RSVD_MASK[7:0]
      : byteIdx == 2'h1 ? nvcr[15:8] | NVCR_RSVD_MASK[15:8] : 8'h00)
    : opcode == OP_RD_VOL ? vcr
    : opcode == OP_RD_EVOL ? evcr : extAddr;
  assign active = (state == ST_DAT) && primed && !selN;
  assign driveMask = cmd.dataLog == LANE_FOUR ? 4'hf
    : cmd.dataLog == LANE_TWO ? 4'h3 : 4'h2;
  assign driveBits = cmd.dataLog == LANE_FOUR ? outShift[7:4]
    : cmd.dataLog == LANE_TWO ? {2'h0, outShift[7:6]} : {2'h0, outShift[7], 1'b0};

  always_comb
  begin
    next_state = state;
    if (selN)
      next_state = ST_IDLE;
    else
      case (state)
        ST_IDLE: next_state = ST_OPC;
        ST_OPC:
          if (opDone)
            next_state = liveCmd.kind == KIND_MEM ? ST_ADR
              : liveCmd.kind == KIND_REG ? ST_DAT
              : liveCmd.kind == KIND_LATCH ? ST_HOLD : ST_IGN;
        ST_ADR:
          if (addrDone)
            next_state = cmd.dummy == 4'h0 ? ST_DAT : ST_DUM;
        ST_DUM:
          if (rise && dumCnt == cmd.dummy - 4'h1)
            next_state = ST_DAT;
        ST_HOLD:
          if (rise)
            next_state = ST_IGN;
        ST_DAT, ST_IGN: next_state = state;
        default: next_state = ST_IDLE;
      endcase
  end

  // Serial engine
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      state <= ST_IDLE;
      sclkLast <= 1'b0;
      cmd <= '0;
      opShift <= 8'h00;
      opBits <= 4'h0;
      opcode <= 8'h00;
      riseCnt <= 8'h00;
      lastIdx <= 8'h00;
      addrShift <= 32'h0;
      addrBits <= 6'h0;
      dumCnt <= 4'h0;
      readAddr <= 32'h0;
    end
    else
    begin
      state <= next_state;
      sclkLast <= sclkNow;
      if (state == ST_IDLE)
      begin
        opShift <= 8'h00;
        opBits <= 4'h0;
        riseCnt <= 8'h00;
        addrShift <= 32'h0;
        addrBits <= 6'h0;
      end
      else
      begin
        if (rise && riseCnt != 8'hff)
          riseCnt <= riseCnt + 8'h01;
        if (state == ST_OPC && rise)
        begin
          opShift <= opNext;
          opBits <= opBits + (4'h1 << laneMode);
        end
        if (state == ST_ADR && addrEdge)
        begin
          addrShift <= addrNext;
          addrBits <= addrBits + {2'h0, addrStep};
        end
      end
      if (opDone)
      begin
        cmd <= liveCmd;
        lastIdx <= liveIdx;
        opcode <= opNext;
      end
      dumCnt <= state == ST_DUM ? dumCnt + {3'h0, rise} : 4'h0;
      if (addrDone)
        readAddr <= opcode == OP_WORD ? {addrNext[31:1], 1'b0} : addrNext;
      else if (loadByte && cmd.kind == KIND_MEM)
        readAddr <= readAddr + 32'h1;
    end

  // Output shifter and lane drivers
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      outShift <= 8'h00;
      outLeft <= 4'h0;
      primed <= 1'b0;
      byteIdx <= 2'h0;
      laneDrive <= {4'h0, 4'hf};
    end
    else
    begin
      if (state != ST_DAT)
      begin
        primed <= 1'b0;
        byteIdx <= 2'h0;
      end
      else if (loadByte)
      begin
        outShift <= cmd.kind == KIND_MEM ? memData : regByte;
        outLeft <= CMD_BITS;
        primed <= 1'b1;
        if (byteIdx != 2'h3)
          byteIdx <= byteIdx + 2'h1;
      end
      else if (outEdge)
      begin
        outShift <= outShift << dataStep;
        outLeft <= outLeft - dataStep;
      end
      laneDrive.data <= active ? driveBits : 4'h0;
      laneDrive.oen <= active ? ~driveMask : 4'hf;
    end

  // Wishbone classic slave
  assign hit = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
  assign wr = wbReq.cyc & wbReq.stb & wbReq.we & wbRsp.ack;
  assign memWr = wr && wbReq.adr == REG_MEMDATA;
  assign rdMux = wbReq.adr == REG_CTRL ? {28'h0, addr4, dtrEn, laneMode}
    : wbReq.adr == REG_FLAGS ? {23'h0, wel, 3'h0, flags}
    : wbReq.adr == REG_CFG ? {evcr, vcr, nvcr}
    : wbReq.adr == REG_EXT ? {18'h0, srHigh, extAddr}
    : wbReq.adr == REG_STAT ? {16'h0, lastIdx, opcode}
    : wbReq.adr == REG_RADDR ? readAddr
    : wbReq.adr == REG_MEMADDR ? {{(32-MEM_BITS){1'b0}}, memAddr} : 32'h0;
  assign wdat = merge(rdMux, wbReq.dat, wbReq.sel);

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      wbRsp <= '0;
      laneMode <= LANE_ONE;
      dtrEn <= 1'b0;
      addr4 <= 1'b0;
      flags <= FLAGS_RESET;
      wel <= 1'b0;
      nvcr <= NVCR_RESET;
      vcr <= VCR_RESET;
      evcr <= EVCR_RESET;
      extAddr <= 8'h00;
      srHigh <= 6'h00;
      memAddr <= '0;
    end
    else
    begin
      wbRsp.ack <= hit;
      wbRsp.dat <= (hit && !wbReq.we) ? rdMux : 32'h0;
      if (wr && wbReq.adr == REG_CTRL)
      begin
        laneMode <= wdat[1:0] == 2'h3 ? LANE_FOUR : wdat[1:0];
        dtrEn <= wdat[CTRL_DTR_BIT];
        addr4 <= wdat[CTRL_ADDR4_BIT];
      end
      if (wr && wbReq.adr == REG_FLAGS)
        flags <= wdat[4:0];
      else if (flagClr)
        flags <= flags & ~FLAG_ERR_MASK;
      if (welSet)
        wel <= 1'b1;
      else if (wr && wbReq.adr == REG_FLAGS)
        wel <= wdat[FL_WEL];
      else if (welClr)
        wel <= 1'b0;
      if (wr && wbReq.adr == REG_CFG)
        {evcr, vcr, nvcr} <= wdat;
      if (wr && wbReq.adr == REG_EXT)
        {srHigh, extAddr} <= wdat[13:0];
      if (wr && wbReq.adr == REG_MEMADDR)
        memAddr <= wdat[MEM_BITS-1:0];
      else if (memWr)
        memAddr <= memAddr + 1'b1;
    end

  property p_addr_index;
    @(posedge clk) disable iff (!rstn) addrDone |-> curIdx == lastIdx;
  endproperty
  a_addr_index: assert property (p_addr_index) else $error("last address clock index wrong");
  property p_latch_extra;
    @(posedge clk) disable iff (!rstn) (state == ST_HOLD && rise && !selN) |=> state == ST_IGN;
  endproperty
  a_latch_extra: assert property (p_latch_extra) else $error("extra clock not ignored");
  property p_wel_set;
    @(posedge clk) disable iff (!rstn) welSet |=> wel ##1 (wel || $past(wr));
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set by enable");
  property p_wdis_prot;
    @(posedge clk) disable iff (!rstn)
      (latchExec && opcode == OP_WDIS && flags[FL_PROT] && !wr) |=> wel == $past(wel);
  endproperty
  a_wdis_prot: assert property (p_wdis_prot) else $error("latch cleared under error");
  property p_one_lane;
    @(posedge clk) disable iff (!rstn) (active && cmd.dataLog == LANE_ONE) |=> laneDrive.oen == 4'hd;
  endproperty
  a_one_lane: assert property (p_one_lane) else $error("one-lane output not on lane one");
  property p_release;
    @(posedge clk) disable iff (!rstn) selN |=> laneDrive.oen == 4'hf;
  endproperty
  a_release: assert property (p_release) else $error("output kept after select high");
  property p_nv_tail;
    @(posedge clk) disable iff (!rstn)
      (loadByte && opcode == OP_RD_NV && byteIdx[1]) |=> outShift == 8'h00;
  endproperty
  a_nv_tail: assert property (p_nv_tail) else $error("nonvolatile tail not zero");
  property p_vol_repeat;
    @(posedge clk) disable iff (!rstn)
      (loadByte && opcode == OP_RD_VOL) |=> outShift == $past(vcr);
  endproperty
  a_vol_repeat: assert property (p_vol_repeat) else $error("volatile byte not repeated");
  property p_word_even;
    @(posedge clk) disable iff (!rstn) (addrDone && opcode == OP_WORD) |=> !readAddr[0];
  endproperty
  a_word_even: assert property (p_word_even) else $error("word read address odd");
  property p_dtr_op;
    @(posedge clk) disable iff (!rstn) (opDone && opNext == OP_DTR_QIO) |=> cmd.dtr;
  endproperty
  a_dtr_op: assert property (p_dtr_op) else $error("double-rate opcode not double rate");
endmodule // serial_flash_front

/* hdl/sync_two.sv */
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes an active-low asynchronous reset already aligned to clk.
module sync_two #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      meta <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
endmodule // sync_two

/* verification/host_model.sv */
// Host side model: drives select, serial clock and lanes; collects output bytes.
// Assumes one caller of frame at a time and the system clock as time base.
module host_model
  import flash_cmd_pkg::*;
(
  input wire logic clk,
  output logic sclkPin,
  output logic selectN,
  output wire logic [3:0] laneIn,
  input flash_cmd_pkg::lanes_out_type laneDrive,
  output logic gotByte,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 6;
  int seed = 21;
  logic drv = 1'b0;
  logic [3:0] drvVal = 4'h0;
  logic [3:0] hostLane = 4'h0;
  // Released lanes toggle at random so no stale level is mistaken for data
  assign laneIn = (hostLane & laneDrive.oen) | (laneDrive.data & ~laneDrive.oen);
  always @(posedge clk) hostLane <= drv ? drvVal : 4'($random(seed));
  initial
  begin
    sclkPin = 1'b0;
    selectN = 1'b1;
    gotByte = 1'b0;
    rxByte = 8'h00;
  end
  task automatic frame(input logic [7:0] op, input logic [1:0] lm, input logic [1:0] al,
    input logic [31:0] adr, input int rises, input int nRd);
    logic [39:0] sh;
    logic [7:0] b;
    int w;
    int k;
    sh = {op, adr};
    w = 1 << lm;
    b = 8'h00;
    @(posedge clk);
    selectN <= 1'b0;
    drv <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < rises + nRd * 8 / w; i++)
    begin
      k = (i < 8 / w) ? w : 1 << al;
      drvVal <= 4'(sh[39:36] >> (4 - k));
      sh = sh << k;
      drv <= (i < rises);
      repeat (H) @(posedge clk);
      b = (b << w) | 8'(lm == 0 ? {3'h0, laneIn[1]} : laneIn & ((4'h1 << w) - 4'h1));
      sclkPin <= 1'b1;
      gotByte <= i >= rises && ((i - rises + 1) * w) % 8 == 0;
      rxByte <= b;
      @(posedge clk);
      gotByte <= 1'b0;
      repeat (H - 1) @(posedge clk);
      sclkPin <= 1'b0;
    end
    repeat (H) @(posedge clk);
    selectN <= 1'b1;
    drv <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // host_model

/* verification/tb_top.sv */
// Self-checking bench: registers, latch commands, memory and register reads.
// Assumes host_model on the serial pins; the bench is the Wishbone master.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_cmd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  wb_req_type wbReq = '0;
  wb_rsp_type wbRsp;
  lanes_out_type laneDrive;
  logic sclkPin;
  logic selectN;
  logic gotByte;
  logic [3:0] laneIn;
  logic [7:0] rxByte;
  int nFail = 0;
  int testsRun = 0;
  int seed = 21;
  logic [31:0] expWord [$];
  logic [7:0] expByte [$];
  logic [7:0] ops [17] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'h6b,
    8'h6c, 8'he7, 8'h0d, 8'h0e, 8'h3d, 8'hbd, 8'h6d, 8'hed};
  // Address shift per lane mode, one lane in the low nibble; f marks a mode the bench skips
  logic [11:0] shf [17] = '{12'h210, 12'h210, 12'h210, 12'h210, 12'hf10, 12'hf10, 12'hf11,
    12'hf11, 12'h2f0, 12'h2f0, 12'h2f2, 12'h321, 12'h321, 12'hf21, 12'hf32, 12'h3f1, 12'h3f3};
  logic [7:0] rOps [6] = '{8'h05, 8'h70, 8'hb5, 8'h85, 8'h65, 8'hc8};
  logic [23:0] rExp [6] = '{24'hababab, 24'hb0b0b0, 24'h552300, 24'h5a5a5a, 24'hdfdfdf,
    24'h3c3c3c};
  always #10 clk = ~clk;
  serial_flash_front #(.MEM_BITS(10)) serial_flash_front_i (.clk(clk), .resetn(resetn),
    .wbReq(wbReq), .wbRsp(wbRsp), .sclkPin(sclkPin), .selectN(selectN), .laneIn(laneIn),
    .laneDrive(laneDrive));
  host_model host_model_i (.clk(clk), .sclkPin(sclkPin), .selectN(selectN), .laneIn(laneIn),
    .laneDrive(laneDrive), .gotByte(gotByte), .rxByte(rxByte));
  task automatic tally_and_finish;
    if (nFail == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmpWord(string what, logic [31:0] exp, logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpByte(logic [7:0] exp, logic [7:0] got);
    cmpWord("serial byte", {24'h0, exp}, {24'h0, got});
  endtask
  task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do
    begin
      @(posedge clk);
    end
    while (wbRsp.ack !== 1'b1);
    wbReq <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expWord.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic fr(logic [7:0] op, int lm, int rises, logic [31:0] flags);
    bus(1'b1, REG_CTRL, 32'(lm));
    host_model_i.frame(op, 2'(lm), 2'h0, 32'h0, rises, 0);
    rd(REG_FLAGS, flags);
  endtask
  always @(posedge clk)
  begin
    if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0)
      cmpWord("bus read", expWord.size() ? expWord.pop_front() : 32'hx, wbRsp.dat);
    if (gotByte === 1'b1)
      cmpByte(expByte.size() ? expByte.pop_front() : 8'hx, rxByte);
  end
  initial
  begin
    logic [3:0] s;
    int idx;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(REG_CTRL, 32'h0);
    rd(REG_FLAGS, {27'h0, FLAGS_RESET});
    rd(REG_CFG, {EVCR_RESET, VCR_RESET, NVCR_RESET});
    rd(8'h20, 32'h0);
    fr(OP_WEN, 2, 2, 32'h102);
    fr(OP_WDIS, 1, 4, 32'h002);
    fr(OP_WEN, 0, 9, 32'h002);
    bus(1'b1, REG_FLAGS, 32'h112);
    fr(OP_WDIS, 0, 8, 32'h112);
    fr(OP_CLRFLAG, 0, 8, 32'h002);
    bus(1'b1, REG_MEMADDR, 32'h3fe);
    bus(1'b1, REG_MEMDATA, 32'ha5);
    bus(1'b1, REG_MEMDATA, 32'h3c);
    bus(1'b1, REG_MEMADDR, 32'h0);
    bus(1'b1, REG_MEMDATA, 32'h7e);
    bus(1'b1, REG_CTRL, 32'h0);
    expByte = '{8'ha5, 8'h3c, 8'h7e};
    host_model_i.frame(OP_READ, 2'h0, 2'h0, 32'h0003fe00, 32, 3);
    rd(REG_STAT, {16'h0, 8'd31, OP_READ});
    bus(1'b1, REG_CTRL, 32'h8);
    host_model_i.frame(OP_READ, 2'h0, 2'h0, 32'h0, 40, 0);
    rd(REG_STAT, {16'h0, 8'd39, OP_READ});
    bus(1'b1, REG_CTRL, 32'h4);
    host_model_i.frame(OP_FAST, 2'h0, 2'h0, 32'h0, 20, 0);
    rd(REG_STAT, {16'h0, 8'd19, OP_FAST});
    for (int m = 0; m < 3; m++)
    begin
      bus(1'b1, REG_CTRL, 32'(m));
      for (int j = 0; j < 17; j++)
      begin
        s = 4'(shf[j] >> (4 * m));
        if (s != 4'hf)
        begin
          idx = (7 >> m) + (((ops[j] inside {8'h13, 8'h0c, 8'h3c, 8'hbc, 8'h6c, 8'h0e}) ? 32 : 24) >> s);
          host_model_i.frame(ops[j], 2'(m), s > 2 ? 2'h2 : 2'(s), $random(seed), idx + 1, 0);
          rd(REG_STAT, {16'h0, 8'(idx), ops[j]});
        end
      end
    end
    bus(1'b1, REG_EXT, 32'h2a3c);
    bus(1'b1, REG_FLAGS, 32'h10f);
    bus(1'b1, REG_CFG, 32'hdf5a2345);
    for (int j = 0; j < 6; j++)
    begin
      bus(1'b1, REG_CTRL, 32'(j % 3));
      for (int k = 2; k >= 0; k--)
        expByte.push_back(rExp[j][8 * k +: 8]);
      host_model_i.frame(rOps[j], 2'(j % 3), 2'h0, 32'h0, 8 >> (j % 3), 3);
      cmpWord("lane enables", 32'hf, {28'h0, laneDrive.oen});
    end
    tally_and_finish;
  end
  initial
  begin
    // Roughly three times the expected length of the run
    repeat (40000) @(posedge clk);
    nFail++;
    tally_and_finish;
  end
endmodule // tb_top
